//--- hw/dmag_pkg.sv
// ----------------------------------------------------------------
// Overview of operation
// - Static RAM answers at data addresses 000H to 19FH and 200H to 2FFH, 672 words of four bits.
// - Display memory of 96 four-bit words answers at 1A0H to 1FFH.
// - Peripheral registers answer at F80H to FFFH through ordinary accesses.
// - Every data address has 12 bits: low 8 from the instruction path, upper 4 from the effective bank.
// - The bank select register holds 0, 1, 2 or 15 and counts only while the bank enable flag is set.
// - Interrupt or call entry saves and clears the bank enable flag; return restores it.
// - Direct 1-bit and 4-bit access with enable clear picks bank 0 below 80H and bank 15 above, else the select.
// - Direct 8-bit access forms the bank the same way and reaches the even word and the next one.
// - Main pointer indirect uses enable AND select as bank; its post-step forms change only the low pointer.
// - Indirect access through either alternate pointer pair always lands in bank 0.
// - 8-bit indirect through the main pointer ignores low pointer bit 0.
// - Fixed-region bit access reaches only FB0H-FBFH and FF0H-FFFH whatever the bank settings.
// - Port bit access: word from operand bits 5:2 and low pointer bits 3:2, bit from low pointer bits 1:0.
// - High pointer plus operand bit access uses enable AND select, the high pointer and the low 4 operand bits.
// - Stack access uses the stack pointer as low address and the stack bank register as bank.
// ----------------------------------------------------------------
package dmag_pkg;
  localparam logic [11:0] RAM_LO_BASE = 12'h000;
  localparam logic [11:0] RAM_LO_TOP = 12'h19f;
  localparam logic [11:0] DISP_BASE = 12'h1a0;
  localparam logic [11:0] DISP_TOP = 12'h1ff;
  localparam logic [11:0] RAM_HI_BASE = 12'h200;
  localparam logic [11:0] RAM_HI_TOP = 12'h2ff;
  localparam logic [11:0] PERI_BASE = 12'hf80;
  localparam logic [3:0] BANK_ZERO = 4'h0;
  localparam logic [3:0] BANK_PERI = 4'hf;
  localparam logic [7:0] FMEM_INT_BASE = 8'hb0;
  localparam logic [7:0] FMEM_PORT_BASE = 8'hf0;
  localparam logic [3:0] RST_BANK_SEL = 4'h0;
  localparam logic [1:0] RST_STACK_BANK = 2'h0;
  localparam logic RST_BANK_EN = 1'b0;
  localparam int BANK_EN_DEPTH = 16;

  // four-state base so the mode can travel on a wire port
  typedef enum logic [3:0] {
    MODE_DIR_1BIT, MODE_DIR_4BIT, MODE_DIR_8BIT,
    MODE_IND_MAIN, MODE_IND_MAIN_INC, MODE_IND_MAIN_DEC, MODE_IND_ALT_A, MODE_IND_ALT_B, MODE_IND_MAIN_8BIT,
    MODE_BIT_FMEM, MODE_BIT_PMEM, MODE_BIT_HMEM, MODE_STACK
  } dmag_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] operand;
    logic [1:0] bit_sel;
  } dmag_req_t;

  typedef struct packed {
    logic [3:0] h;
    logic [3:0] l;
    logic [3:0] d;
    logic [3:0] e;
    logic [7:0] stack_pointer;
  } dmag_ptr_t;

  typedef struct packed {
    logic [11:0] addr;
    logic pair;
    logic [1:0] bit_idx;
    logic ram_hit;
    logic disp_hit;
    logic peri_hit;
    logic store_en;
  } dmag_addr_t;
endpackage : dmag_pkg

//--- hw/dmag_top.sv
`timescale 1ns/10ps
`default_nettype none
module dmag_top
  import dmag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire dmag_mode_t mode,
  input wire dmag_req_t req,
  input wire dmag_ptr_t ptr,
  input wire logic bank_select_wr,
  input wire logic [3:0] bank_select_wdata,
  input wire logic stack_bank_wr,
  input wire logic [3:0] stack_bank_wdata,
  input wire logic bank_enable_wr,
  input wire logic bank_enable_wdata,
  input wire logic call_entry,
  input wire logic call_return,
  output logic [3:0] bank_select_reg,
  output logic [1:0] stack_bank_reg,
  output logic bank_enable_flag,
  output logic [3:0] effective_bank,
  output dmag_addr_t addr_out,
  output logic addr_valid,
  output logic l_update,
  output logic [3:0] l_next,
  output logic save_overflow
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_sync1_ff;
  logic rst_sync2_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  wire rst_core_n = rst_sync2_ff;

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic [3:0] direct_bank(input logic en, input logic [3:0] sel, input logic [7:0] op);
    if (en) begin
      direct_bank = sel;
    end else begin
      direct_bank = op[7] ? BANK_PERI : BANK_ZERO;
    end
  endfunction : direct_bank

  // ----------------------------------------------------------------
  // bank registers and enable save stack
  // ----------------------------------------------------------------
  logic [3:0] bank_sel_ff;
  logic [1:0] stack_bank_ff;
  logic bank_en_ff;
  logic [BANK_EN_DEPTH-1:0] save_ff;
  logic [4:0] save_cnt_ff;
  logic overflow_ff;
  // only 0, 1, 2 and 15 are legal; other values are held off
  wire sel_legal = (bank_select_wdata <= 4'h2) || (bank_select_wdata == BANK_PERI);
  wire save_full = (save_cnt_ff == 5'(BANK_EN_DEPTH));
  wire save_empty = (save_cnt_ff == 5'h00);

  always_ff @(posedge ref_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      bank_sel_ff <= RST_BANK_SEL;
      stack_bank_ff <= RST_STACK_BANK;
      bank_en_ff <= RST_BANK_EN;
      save_ff <= '0;
      save_cnt_ff <= 5'h00;
      overflow_ff <= 1'b0;
    end else begin
      if (bank_select_wr && sel_legal) begin
        bank_sel_ff <= bank_select_wdata;
      end
      if (stack_bank_wr) begin
        // upper bits are software's duty; only the low two are kept
        stack_bank_ff <= stack_bank_wdata[1:0];
      end
      if (call_entry) begin
        save_ff <= {save_ff[BANK_EN_DEPTH-2:0], bank_en_ff};
        bank_en_ff <= 1'b0;
        if (!save_full) begin
          save_cnt_ff <= save_cnt_ff + 5'h01;
        end else begin
          overflow_ff <= 1'b1;
        end
      end else if (call_return) begin
        save_ff <= {1'b0, save_ff[BANK_EN_DEPTH-1:1]};
        bank_en_ff <= save_ff[0];
        if (!save_empty) begin
          save_cnt_ff <= save_cnt_ff - 5'h01;
        end
      end else if (bank_enable_wr) begin
        bank_en_ff <= bank_enable_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------
  wire [3:0] and_bank = bank_en_ff ? bank_sel_ff : BANK_ZERO;
  wire [3:0] dir_bank = direct_bank(bank_en_ff, bank_sel_ff, req.operand);
  wire [3:0] stk_bank = {2'b00, stack_bank_ff};
  wire [7:0] main_ptr = {ptr.h, ptr.l};
  // operand bit 6 picks the port window, low nibble the word
  wire [3:0] fmem_hi = req.operand[6] ? FMEM_PORT_BASE[7:4] : FMEM_INT_BASE[7:4];

  logic [11:0] nxt_addr;
  logic [3:0] nxt_bank;
  logic nxt_pair;
  logic [1:0] nxt_bit;
  logic nxt_lupd;
  logic [3:0] nxt_l;
  always_comb begin
    nxt_bank = and_bank;
    nxt_addr = 12'h000;
    nxt_pair = 1'b0;
    nxt_bit = req.bit_sel;
    nxt_lupd = 1'b0;
    nxt_l = ptr.l;
    case (mode)
      MODE_DIR_1BIT, MODE_DIR_4BIT: begin
        nxt_bank = dir_bank;
        nxt_addr = {dir_bank, req.operand};
      end
      MODE_DIR_8BIT: begin
        nxt_bank = dir_bank;
        nxt_addr = {dir_bank, req.operand[7:1], 1'b0};
        nxt_pair = 1'b1;
      end
      MODE_IND_MAIN: nxt_addr = {and_bank, main_ptr};
      MODE_IND_MAIN_INC: begin
        nxt_addr = {and_bank, main_ptr};
        nxt_lupd = 1'b1;
        nxt_l = ptr.l + 4'h1;
      end
      MODE_IND_MAIN_DEC: begin
        nxt_addr = {and_bank, main_ptr};
        nxt_lupd = 1'b1;
        nxt_l = ptr.l - 4'h1;
      end
      MODE_IND_ALT_A: begin
        nxt_bank = BANK_ZERO;
        nxt_addr = {BANK_ZERO, ptr.d, ptr.e};
      end
      MODE_IND_ALT_B: begin
        nxt_bank = BANK_ZERO;
        nxt_addr = {BANK_ZERO, ptr.d, ptr.l};
      end
      MODE_IND_MAIN_8BIT: begin
        nxt_addr = {and_bank, ptr.h, ptr.l[3:1], 1'b0};
        nxt_pair = 1'b1;
      end
      MODE_BIT_FMEM: begin
        nxt_bank = BANK_PERI;
        nxt_addr = {BANK_PERI, fmem_hi, req.operand[3:0]};
      end
      MODE_BIT_PMEM: begin
        nxt_bank = BANK_PERI;
        nxt_addr = {BANK_PERI, 2'b11, req.operand[5:2], ptr.l[3:2]};
        nxt_bit = ptr.l[1:0];
      end
      MODE_BIT_HMEM: nxt_addr = {and_bank, ptr.h, req.operand[3:0]};
      MODE_STACK: begin
        nxt_bank = stk_bank;
        nxt_addr = {stk_bank, ptr.stack_pointer};
      end
      default: nxt_addr = 12'h000;
    endcase
  end

  wire hit_ram = in_range(nxt_addr, RAM_LO_BASE, RAM_LO_TOP) || in_range(nxt_addr, RAM_HI_BASE, RAM_HI_TOP);
  wire hit_disp = in_range(nxt_addr, DISP_BASE, DISP_TOP);
  wire hit_peri = (nxt_addr >= PERI_BASE);
  wire hit_any = hit_ram || hit_disp || hit_peri;

  // ----------------------------------------------------------------
  // registered address output
  // ----------------------------------------------------------------
  dmag_addr_t addr_ff;
  logic valid_ff;
  logic lupd_ff;
  logic [3:0] lnext_ff;
  logic [3:0] eff_bank_ff;
  always_ff @(posedge ref_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      addr_ff <= '0;
      valid_ff <= 1'b0;
      lupd_ff <= 1'b0;
      lnext_ff <= 4'h0;
      eff_bank_ff <= BANK_ZERO;
    end else begin
      valid_ff <= req.valid;
      lupd_ff <= req.valid && nxt_lupd;
      lnext_ff <= nxt_l;
      eff_bank_ff <= nxt_bank;
      addr_ff.addr <= nxt_addr;
      addr_ff.pair <= nxt_pair;
      addr_ff.bit_idx <= nxt_bit;
      addr_ff.ram_hit <= hit_ram;
      addr_ff.disp_hit <= hit_disp;
      addr_ff.peri_hit <= hit_peri;
      // unmapped addresses never strobe storage
      addr_ff.store_en <= req.valid && req.write && hit_any;
    end
  end

  assign bank_select_reg = bank_sel_ff;
  assign stack_bank_reg = stack_bank_ff;
  assign bank_enable_flag = bank_en_ff;
  assign effective_bank = eff_bank_ff;
  assign addr_out = addr_ff;
  assign addr_valid = valid_ff;
  assign l_update = lupd_ff;
  assign l_next = lnext_ff;
  assign save_overflow = overflow_ff;
endmodule : dmag_top
`default_nettype wire

//--- verification/dmag_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dmag_properties
  import dmag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire dmag_mode_t mode,
  input wire dmag_req_t req,
  input wire dmag_ptr_t ptr,
  input wire logic call_entry,
  input wire logic [3:0] bank_select_reg,
  input wire logic [1:0] stack_bank_reg,
  input wire logic bank_enable_flag,
  input wire dmag_addr_t addr_out,
  input wire logic addr_valid,
  input wire logic l_update,
  input wire logic [3:0] l_next
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [3:0] and_bank = bank_enable_flag ? bank_select_reg : 4'h0;
  wire [3:0] dir_bank = bank_enable_flag ? bank_select_reg : {4{req.operand[7]}};
  wire [11:0] a = addr_out.addr;
  property p_answer; req.valid |=> addr_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");
  property p_dir; req.valid && mode == MODE_DIR_4BIT |=> a == {$past(dir_bank), $past(req.operand)}; endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");
  property p_hl; req.valid && mode == MODE_IND_MAIN |=>
    a == {$past(and_bank), $past(ptr.h), $past(ptr.l)}; endproperty
  a_hl: assert property (p_hl) else $error("main pointer address wrong");
  property p_alt; req.valid && mode inside {MODE_IND_ALT_A, MODE_IND_ALT_B} |=> a[11:8] == 4'h0; endproperty
  a_alt: assert property (p_alt) else $error("alternate pointer left bank zero");
  property p_even; req.valid && mode inside {MODE_DIR_8BIT, MODE_IND_MAIN_8BIT} |=> !a[0] && addr_out.pair; endproperty
  a_even: assert property (p_even) else $error("pair access not even");
  property p_stack; req.valid && mode == MODE_STACK |=>
    a == {2'h0, $past(stack_bank_reg), $past(ptr.stack_pointer)}; endproperty
  a_stack: assert property (p_stack) else $error("stack address wrong");
  property p_inc; req.valid && mode == MODE_IND_MAIN_INC |=> l_update && l_next == $past(ptr.l) + 4'h1; endproperty
  a_inc: assert property (p_inc) else $error("low pointer increment wrong");
  property p_fmem; req.valid && mode == MODE_BIT_FMEM |=> a[11:4] inside {8'hfb, 8'hff}; endproperty
  a_fmem: assert property (p_fmem) else $error("fixed bit region left");
  property p_entry; call_entry |=> !bank_enable_flag; endproperty
  a_entry: assert property (p_entry) else $error("enable flag not cleared on entry");
  property p_sel; bank_select_reg inside {4'h0, 4'h1, 4'h2, 4'hf}; endproperty
  a_sel: assert property (p_sel) else $error("bank select holds illegal value");
endmodule : dmag_properties
bind dmag_top dmag_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n), .mode(mode), .req(req), .ptr(ptr),
  .call_entry(call_entry), .bank_select_reg(bank_select_reg), .stack_bank_reg(stack_bank_reg),
  .bank_enable_flag(bank_enable_flag), .addr_out(addr_out), .addr_valid(addr_valid), .l_update(l_update),
  .l_next(l_next));
`default_nettype wire

//--- verification/dmag_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmag_core_model
  import dmag_pkg::*;
(
  input wire logic ref_clk,
  output dmag_mode_t mode,
  output dmag_req_t req,
  output dmag_ptr_t ptr
);
  initial begin
    mode = MODE_DIR_1BIT;
    req = '0;
    ptr = '0;
  end
  task automatic issue(input dmag_mode_t m, input logic [7:0] op, input logic wr, input dmag_ptr_t p);
    @(posedge ref_clk);
    mode <= m;
    req <= '{valid: 1'b1, write: wr, operand: op, bit_sel: 2'h1};
    ptr <= p;
    @(posedge ref_clk);
    // operands scrambled once released, so a late sample cannot match
    req <= '{valid: 1'b0, write: ~wr, operand: ~op, bit_sel: 2'h2};
    ptr <= ~p;
  endtask : issue
endmodule : dmag_core_model
`default_nettype wire

//--- verification/data_memory_address_generator_test.sv
`timescale 1ns/10ps
`default_nettype none
module data_memory_address_generator_test
  import dmag_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  localparam int SEL_WR = 0, STK_WR = 1, EN_WR = 2, ENTRY = 3, RET = 4;
  logic [4:0] strobe = 5'h00;
  wire bank_select_wr = strobe[SEL_WR];
  wire stack_bank_wr = strobe[STK_WR];
  wire bank_enable_wr = strobe[EN_WR];
  wire call_entry = strobe[ENTRY];
  wire call_return = strobe[RET];
  logic [3:0] bank_select_wdata = 4'h0, stack_bank_wdata = 4'h0;
  logic bank_enable_wdata = 1'b0;
  int bad_count = 0;
  int tests_run = 0;
  dmag_mode_t mode;
  dmag_req_t req;
  dmag_ptr_t ptr;
  dmag_addr_t addr_out;
  logic [3:0] bank_select_reg, effective_bank, l_next;
  logic [1:0] stack_bank_reg;
  logic bank_enable_flag, addr_valid, l_update, save_overflow;
  wire [3:0] hits = {addr_out.ram_hit, addr_out.disp_hit, addr_out.peri_hit, addr_out.store_en};
  always #20 ref_clk = ~ref_clk;
  dmag_core_model core (.ref_clk(ref_clk), .mode(mode), .req(req), .ptr(ptr));
  dmag_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .mode(mode), .req(req), .ptr(ptr),
    .bank_select_wr(bank_select_wr), .bank_select_wdata(bank_select_wdata), .stack_bank_wr(stack_bank_wr),
    .stack_bank_wdata(stack_bank_wdata), .bank_enable_wr(bank_enable_wr), .bank_enable_wdata(bank_enable_wdata),
    .call_entry(call_entry), .call_return(call_return), .bank_select_reg(bank_select_reg),
    .stack_bank_reg(stack_bank_reg), .bank_enable_flag(bank_enable_flag), .effective_bank(effective_bank),
    .addr_out(addr_out), .addr_valid(addr_valid), .l_update(l_update), .l_next(l_next),
    .save_overflow(save_overflow));
  task automatic wrap_up;
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input dmag_mode_t m, input logic [7:0] op, input logic [11:0] e, input dmag_ptr_t p = '0);
    core.issue(m, op, 1'b0, p);
    #1 chk("addr", e, addr_out.addr);
  endtask : acc
  task automatic pls(input int k);
    @(posedge ref_clk);
    strobe[k] <= 1'b1;
    @(posedge ref_clk);
    strobe[k] <= 1'b0;
    #1;
  endtask : pls
  task automatic setb(input logic [3:0] sel, input logic en);
    @(posedge ref_clk);
    bank_select_wdata <= sel;
    bank_enable_wdata <= en;
    pls(SEL_WR);
    pls(EN_WR);
  endtask : setb
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    acc(MODE_DIR_4BIT, 8'h7f, 12'h07f);
    acc(MODE_DIR_1BIT, 8'h80, 12'hf80);
    chk("hits", 12'h002, 12'(hits));
    setb(4'h1, 1'b1);
    acc(MODE_DIR_4BIT, 8'ha5, 12'h1a5);
    chk("hits", 12'h004, 12'(hits));
    acc(MODE_DIR_8BIT, 8'h35, 12'h134);
    chk("pair", 12'h001, 12'(addr_out.pair));
    setb(4'h5, 1'b0);
    chk("sel", 12'h001, 12'(bank_select_reg));
    setb(4'h2, 1'b1);
    acc(MODE_IND_MAIN, 8'h00, 12'h234, 24'h34_0000);
    chk("hits", 12'h008, 12'(hits));
    acc(MODE_IND_MAIN_INC, 8'h00, 12'h23f, 24'h3f_0000);
    chk("lnext", 12'h010, 12'({l_update, l_next}));
    acc(MODE_IND_MAIN_DEC, 8'h00, 12'h230, 24'h30_0000);
    chk("lnext", 12'h01f, 12'({l_update, l_next}));
    acc(MODE_IND_ALT_A, 8'h00, 12'h012, 24'h00_1200);
    chk("bank", 12'h000, 12'(effective_bank));
    acc(MODE_IND_ALT_B, 8'h00, 12'h017, 24'h07_1000);
    acc(MODE_IND_MAIN_8BIT, 8'h00, 12'h234, 24'h35_0000);
    acc(MODE_BIT_HMEM, 8'h2b, 12'h27b, 24'h70_0000);
    acc(MODE_BIT_FMEM, 8'h45, 12'hff5);
    acc(MODE_BIT_FMEM, 8'h05, 12'hfb5);
    acc(MODE_BIT_PMEM, 8'h14, 12'hfd6, 24'h09_0000);
    chk("bit", 12'h001, 12'(addr_out.bit_idx));
    @(posedge ref_clk);
    stack_bank_wdata <= 4'h2;
    pls(STK_WR);
    acc(MODE_STACK, 8'h00, 12'h240, 24'h00_0040);
    chk("bank", 12'h002, 12'(effective_bank));
    pls(ENTRY);
    chk("flag", 12'h000, 12'(bank_enable_flag));
    pls(RET);
    chk("flag", 12'h001, 12'(bank_enable_flag));
    setb(4'hf, 1'b1);
    core.issue(MODE_DIR_4BIT, 8'h85, 1'b1, '0);
    #1 chk("hits", 12'h003, 12'(hits));
    chk("bank", 12'h00f, 12'(effective_bank));
    core.issue(MODE_DIR_4BIT, 8'h10, 1'b1, '0);
    #1 chk("hits", 12'h000, 12'(hits));
    repeat (BANK_EN_DEPTH) pls(ENTRY);
    chk("ovf", 12'h000, 12'(save_overflow));
    pls(ENTRY);
    chk("ovf", 12'h001, 12'(save_overflow));
    wrap_up;
  end
endmodule : data_memory_address_generator_test
`default_nettype wire
